// *** in_sync.v ***
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module in_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire [W-1:0] i_async,
   output reg [W-1:0] o_sync
);
   reg [W-1:0] meta_r;

   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // in_sync

// *** lipc_monitor.sv ***
// Port-level assertions for the live-insertion power control block
`timescale 1ns/1ps
module lipc_monitor (
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire o_wb_ack,
   input wire i_board_present_n,
   input wire i_power_request,
   input wire i_excess_voltage_sense,
   input wire [2:0] i_bus_id_straps_hi,
   input wire [2:0] i_bus_id_straps_lo,
   input wire o_gate_on,
   input wire [4:0] o_bus_id
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   // Two sync flops then the output register
   sequence s_gate_off;
      ##3 !o_gate_on;
   endsequence
   sequence s_straps_open;
      (i_bus_id_straps_hi == 3'h0 && i_bus_id_straps_lo == 3'h0) [*3];
   endsequence
   a_absent_gate_off: assert property (i_board_present_n |-> s_gate_off)
      else $error("gate on while board absent");
   a_excess_gate_off: assert property (i_excess_voltage_sense |-> s_gate_off)
      else $error("gate on during excess voltage");
   a_req_fall_off: assert property ($fell(i_power_request) |-> s_gate_off)
      else $error("gate on after request fell");
   a_rise_needs_card: assert property ($rose(o_gate_on) |-> !$past(i_board_present_n, 3))
      else $error("gate rose without seated card");
   a_rise_no_excess: assert property ($rose(o_gate_on) |-> !$past(i_excess_voltage_sense, 3))
      else $error("gate rose during excess voltage");
   a_open_straps_id: assert property (s_straps_open |=> o_bus_id == 5'h1A)
      else $error("open straps not decoded");
   a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
endmodule // lipc_monitor
bind live_insert_power_control lipc_monitor u_lipc_monitor (.*);

// *** live_insert_consts.vh ***
// Constants for the live-insertion power control block
// Notes on behaviour
// - Card seated (present low) permits switch on
// - Present high forces pass switch drive off
// - Each present-input change logs an event bit
// - Present falling: sample request, clear faults
// - Request rising switches on, falling switches off
// - Power-up: command bit follows request after 100ms
// - Request low at power-up: wait for host
// - Request falling edge clears fault register
// - Output sense below threshold means power bad
// - Config bits select pull-low or release on bad
// - Power-bad fault only after start-up, drive on
// - Reset default: pin pulls low when bad
// - Fault pulls the alert line low
// - Alert only for faults enabled in alert-enable
// - Excess voltage logs fault, drive switched off
// - Three-state straps decode to 27 addresses
// - Low-voltage reset clears faults, re-permits drive
// - Reset clears faults, sets control defaults
`ifndef LIVE_INSERT_CONSTS_VH
`define LIVE_INSERT_CONSTS_VH

// Register byte offsets
`define REG_CONTROL 8'h00
`define REG_FAULT 8'h04
`define REG_ALERT_EN 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_MASK 8'h10

// Control register fields
`define SWITCH_CMD_BIT_POS 3
`define PG_PIN_CFG_HI 6
`define PG_PIN_CFG_LO 7
`define CONTROL_RST 8'h00

// Fault / alert-enable / irq-mask layout
`define FAULT_EXCESS_V 0
`define FAULT_POWER_BAD 1
`define FAULT_PRESENT_CHG 2
`define FAULT_W 3
`define FAULT_RST 3'h0
`define ALERT_EN_RST 3'h0
`define IRQ_MASK_RST 3'h0

// Pin config codes {cfg_lo, cfg_hi}
`define PG_CFG_LOW_ON_BAD 2'h0
`define PG_CFG_RELEASE_ON_BAD 2'h1
`define PG_CFG_RELEASED 2'h2
`define PG_CFG_LOW 2'h3

// Status register fields
`define ST_PRESENT_N 0
`define ST_REQUEST 1
`define ST_POWER_GOOD 2
`define ST_EXCESS_V 3
`define ST_GATE_ON 4
`define ST_STARTUP_DONE 5
`define ST_BUS_ID_LSB 8

// Strap decode codes
`define TRIT_LOW 2'h0
`define TRIT_HIGH 2'h1
`define TRIT_OPEN 2'h2

// Timing
`define SYS_CLK_KHZ 100000
`define POWERUP_DELAY_MS 100
`define STARTUP_TIME_MS 100

`endif

// *** live_insert_power_control.v ***
// Switch control, fault logging and register slave for live insertion
`include "live_insert_consts.vh"
`timescale 1ns/1ps
module live_insert_power_control #(
   parameter POWERUP_CYC = `POWERUP_DELAY_MS * `SYS_CLK_KHZ,
   parameter STARTUP_CYC = `STARTUP_TIME_MS * `SYS_CLK_KHZ
) (
   input wire i_sys_clk,
   input wire i_sys_rst,
   // Wishbone classic slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [7:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg o_wb_ack,
   output reg [31:0] o_wb_dat,
   // Comparator and pin inputs
   input wire i_board_present_n,
   input wire i_power_request,
   input wire i_output_level_sense,
   input wire i_excess_voltage_sense,
   input wire i_low_voltage_sense,
   input wire [2:0] i_bus_id_straps_hi,
   input wire [2:0] i_bus_id_straps_lo,
   // Outputs
   output reg o_gate_on,
   output reg o_gpio_out,
   output reg o_gpio_oe,
   output reg o_alert_out,
   output reg o_alert_oe,
   output reg o_irq,
   output reg [4:0] o_bus_id
);
   localparam ST_INIT = 2'h0;
   localparam ST_OFF = 2'h1;
   localparam ST_RAMP = 2'h2;
   localparam ST_ON = 2'h3;
   localparam CNT_W = 32;
   // Counter end points sized to the counter
   localparam [CNT_W-1:0] POWERUP_LAST = POWERUP_CYC - 1;
   localparam [CNT_W-1:0] STARTUP_LAST = STARTUP_CYC - 1;
   localparam [10:0] SYNC_RST = 11'h001;

   wire [10:0] pin_async;
   wire [10:0] sync_w;
   wire present_n;
   wire request;
   wire power_good;
   wire excess_v;
   wire low_v_reset;
   wire [2:0] strap_hi;
   wire [2:0] strap_lo;
   wire [1:0] trit0;
   wire [1:0] trit1;
   wire [1:0] trit2;

   // Bit order here fixes the sync_w slices below
   assign pin_async = {
      i_bus_id_straps_lo,
      i_bus_id_straps_hi,
      i_low_voltage_sense,
      i_excess_voltage_sense,
      i_output_level_sense,
      i_power_request,
      i_board_present_n
   };

   in_sync #(
      .W(11),
      .RST_VAL(SYNC_RST)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(pin_async),
      .o_sync(sync_w)
   );

   assign present_n = sync_w[0];
   assign request = sync_w[1];
   assign power_good = sync_w[2];
   assign excess_v = sync_w[3];
   assign low_v_reset = sync_w[4];
   assign strap_hi = sync_w[7:5];
   assign strap_lo = sync_w[10:8];

   // Each strap decoded alone from its settled comparator pair
   strap_decode u_strap0 (
      .i_above_hi(strap_hi[0]),
      .i_below_lo(strap_lo[0]),
      .o_trit(trit0)
   );
   strap_decode u_strap1 (
      .i_above_hi(strap_hi[1]),
      .i_below_lo(strap_lo[1]),
      .o_trit(trit1)
   );
   strap_decode u_strap2 (
      .i_above_hi(strap_hi[2]),
      .i_below_lo(strap_lo[2]),
      .o_trit(trit2)
   );

   reg [7:0] control_r;
   reg [7:0] control_nxt;
   reg [`FAULT_W-1:0] fault_r;
   reg [`FAULT_W-1:0] fault_nxt;
   reg [`FAULT_W-1:0] alert_en_r;
   reg [`FAULT_W-1:0] irq_mask_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [CNT_W-1:0] cnt_r;
   reg [CNT_W-1:0] cnt_nxt;
   reg present_n_q_r;
   reg request_q_r;
   reg gate_nxt;
   reg gpio_oe_nxt;
   reg [`FAULT_W-1:0] fault_set;
   reg [`FAULT_W-1:0] fault_wclr;
   reg fault_clr_all;
   reg [31:0] rd_data;
   reg [4:0] bus_id_nxt;
   reg [2:0] settle_r;

   // Sync flops show reset values for two edges; mask the fake edges
   wire edge_ok = settle_r[2];
   wire present_fall = edge_ok & present_n_q_r & ~present_n;
   wire present_edge = edge_ok & (present_n_q_r ^ present_n);
   wire request_rise = edge_ok & ~request_q_r & request;
   wire request_fall = edge_ok & request_q_r & ~request;
   wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   wire wb_wr = wb_req & i_wb_we & i_wb_sel[0];
   // One write strobe per writable register; status is read-only and has none
   wire wr_control = wb_wr & (i_wb_adr == `REG_CONTROL);
   wire wr_fault = wb_wr & (i_wb_adr == `REG_FAULT);
   wire wr_alert_en = wb_wr & (i_wb_adr == `REG_ALERT_EN);
   wire wr_irq_mask = wb_wr & (i_wb_adr == `REG_IRQ_MASK);
   wire powerup_end = (state_r == ST_INIT) && (cnt_r == POWERUP_LAST);
   wire startup_done = (state_r == ST_ON);
   wire [1:0] pg_cfg = {control_r[`PG_PIN_CFG_LO],
      control_r[`PG_PIN_CFG_HI]};

   // Edge history for pin inputs
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         present_n_q_r <= 1'b1;
         request_q_r <= 1'b0;
         settle_r <= 3'h0;
      end else begin
         present_n_q_r <= present_n;
         request_q_r <= request;
         // Fills once the history holds real pin data
         settle_r <= {settle_r[1:0], 1'b1};
      end
   end

   // Control register: host writes, then pin events on top
   always @* begin
      control_nxt = control_r;
      if (wr_control)
         control_nxt = i_wb_dat[7:0];
      // Power-up: command bit adopts the request level once delay ends
      if (powerup_end)
         control_nxt[`SWITCH_CMD_BIT_POS] = request;
      if (request_rise)
         control_nxt[`SWITCH_CMD_BIT_POS] = 1'b1;
      if (request_fall)
         control_nxt[`SWITCH_CMD_BIT_POS] = 1'b0;
      // Insertion has the last word
      if (present_fall)
         control_nxt[`SWITCH_CMD_BIT_POS] = request;
   end

   // Fault logging; a new event wins over any clear in the same cycle
   always @* begin
      fault_set = {`FAULT_W{1'b0}};
      fault_set[`FAULT_EXCESS_V] = excess_v;
      fault_set[`FAULT_POWER_BAD] = ~power_good & startup_done
         & o_gate_on;
      fault_set[`FAULT_PRESENT_CHG] = present_edge;
      // Clears wipe the log; events of the same cycle still land
      fault_clr_all = present_fall | request_fall
         | low_v_reset;
      fault_wclr = {`FAULT_W{1'b0}};
      if (wr_fault)
         fault_wclr = i_wb_dat[`FAULT_W-1:0];
      fault_nxt = fault_r;
      if (fault_clr_all)
         fault_nxt = {`FAULT_W{1'b0}};
      fault_nxt = (fault_nxt & ~fault_wclr) | fault_set;
   end

   // Drive permitted only with card seated and no excess-voltage fault
   always @* begin
      gate_nxt = control_nxt[`SWITCH_CMD_BIT_POS] & ~present_n
         & ~fault_nxt[`FAULT_EXCESS_V];
      // Power-up window keeps the drive off whatever the command says
      if (state_r == ST_INIT)
         gate_nxt = 1'b0;
   end

   // Start-up sequence: power-up delay, then ramp window after turn-on
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_INIT: begin
            if (powerup_end) begin
               state_nxt = ST_OFF;
               cnt_nxt = {CNT_W{1'b0}};
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         ST_OFF: begin
            cnt_nxt = {CNT_W{1'b0}};
            if (gate_nxt)
               state_nxt = ST_RAMP;
         end
         // Drive dropping at any point sends the sequence back to off; the ramp window restarts at next turn-on
         ST_RAMP: begin
            if (!gate_nxt) begin
               state_nxt = ST_OFF;
               cnt_nxt = {CNT_W{1'b0}};
            end else if (cnt_r == STARTUP_LAST) begin
               state_nxt = ST_ON;
            end else begin
               cnt_nxt = cnt_r + 1'b1;
            end
         end
         ST_ON: begin
            if (!gate_nxt) begin
               state_nxt = ST_OFF;
               cnt_nxt = {CNT_W{1'b0}};
            end
         end
         default: begin
            state_nxt = ST_INIT;
            cnt_nxt = {CNT_W{1'b0}};
         end
      endcase
   end

   // Power-good pin; a pulled-low pin reads as bad at reset
   always @* begin
      case (pg_cfg)
         `PG_CFG_LOW_ON_BAD: gpio_oe_nxt = ~power_good;
         `PG_CFG_RELEASE_ON_BAD: gpio_oe_nxt = power_good;
         `PG_CFG_RELEASED: gpio_oe_nxt = 1'b0;
         default: gpio_oe_nxt = 1'b1;
      endcase
   end

   // Bus address from three three-state straps
   always @* begin
      bus_id_nxt = trit2 * 5'd9 + trit1 * 5'd3 + {3'h0, trit0};
   end

   // Register read mux; unmapped addresses read zero
   always @* begin
      rd_data = 32'h0000_0000;
      if (i_wb_adr == `REG_CONTROL) begin
         rd_data[7:0] = control_r;
      end else if (i_wb_adr == `REG_FAULT) begin
         rd_data[`FAULT_W-1:0] = fault_r;
      end else if (i_wb_adr == `REG_ALERT_EN) begin
         rd_data[`FAULT_W-1:0] = alert_en_r;
      end else if (i_wb_adr == `REG_STATUS) begin
         rd_data[`ST_PRESENT_N] = present_n;
         rd_data[`ST_REQUEST] = request;
         rd_data[`ST_POWER_GOOD] = power_good;
         rd_data[`ST_EXCESS_V] = excess_v;
         rd_data[`ST_GATE_ON] = o_gate_on;
         rd_data[`ST_STARTUP_DONE] = startup_done;
         rd_data[`ST_BUS_ID_LSB+4:`ST_BUS_ID_LSB] = o_bus_id;
      end else if (i_wb_adr == `REG_IRQ_MASK) begin
         rd_data[`FAULT_W-1:0] = irq_mask_r;
      end
   end

   // Register file
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         control_r <= `CONTROL_RST;
         fault_r <= `FAULT_RST;
         alert_en_r <= `ALERT_EN_RST;
         irq_mask_r <= `IRQ_MASK_RST;
      end else begin
         control_r <= control_nxt;
         fault_r <= fault_nxt;
         if (wr_alert_en)
            alert_en_r <= i_wb_dat[`FAULT_W-1:0];
         if (wr_irq_mask)
            irq_mask_r <= i_wb_dat[`FAULT_W-1:0];
      end
   end

   // Sequencer state and its shared counter
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r <= ST_INIT;
         cnt_r <= {CNT_W{1'b0}};
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Pin outputs; alert and irq follow the fault value being stored
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_gate_on <= 1'b0;
         o_gpio_out <= 1'b0;
         o_gpio_oe <= 1'b1;
         o_alert_out <= 1'b0;
         o_alert_oe <= 1'b0;
         o_irq <= 1'b0;
         o_bus_id <= 5'h00;
      end else begin
         o_gate_on <= gate_nxt;
         // Open-drain pins only ever pull low; the enable does the work
         o_gpio_out <= 1'b0;
         o_gpio_oe <= gpio_oe_nxt;
         o_alert_out <= 1'b0;
         o_alert_oe <= |(fault_nxt & alert_en_r);
         o_irq <= |(fault_nxt & irq_mask_r);
         o_bus_id <= bus_id_nxt;
      end
   end

   // Bus answer; ack one cycle after the request, dropped the next
   always @(posedge i_sys_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req)
            o_wb_dat <= rd_data;
      end
   end
endmodule // live_insert_power_control

// *** live_insert_power_control_tb.sv ***
// Self-checking bench for the live-insertion power control block
`timescale 1ns/1ps
module live_insert_power_control_tb;
   logic clk = 0;
   logic rst = 1;
   logic cyc = 0;
   logic stb = 0;
   logic we = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd;
   logic pres_n = 0;
   logic req = 0;
   logic exc = 0;
   logic low_v = 0;
   logic short = 0;
   logic [2:0] st_hi = 3'h0;
   logic [2:0] st_lo = 3'h0;
   wire ack, gate, gp_out, gp_oe, al_out, al_oe, irq, good;
   wire [31:0] rdat;
   wire [4:0] bus_id;
   int failures = 0;
   int tests_run = 0;
   int tr[3];
   initial forever #5 clk = ~clk;
   live_insert_power_control #(.POWERUP_CYC(20), .STARTUP_CYC(30))
      u_live_insert_power_control (.i_sys_clk(clk), .i_sys_rst(rst),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
      .i_board_present_n(pres_n), .i_power_request(req),
      .i_output_level_sense(good), .i_excess_voltage_sense(exc),
      .i_low_voltage_sense(low_v), .i_bus_id_straps_hi(st_hi),
      .i_bus_id_straps_lo(st_lo), .o_gate_on(gate), .o_gpio_out(gp_out),
      .o_gpio_oe(gp_oe), .o_alert_out(al_out), .o_alert_oe(al_oe),
      .o_irq(irq), .o_bus_id(bus_id));
   load_stage_model u_load_stage_model (.i_sys_clk(clk), .i_gate_on(gate),
      .i_short(short), .o_level_good(good));
   function automatic logic [4:0] exp_id(input int t[3]);
      return 5'(t[2] * 9 + t[1] * 3 + t[0]);
   endfunction
   function automatic logic exp_pin(input logic [1:0] c, input logic ok);
      return c == 2'h3 || (c == 2'h0 && !ok) || (c == 2'h1 && ok);
   endfunction
   task automatic summarize;
      if (failures == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
      if (n >= 50) begin
         failures++;
         summarize();
      end
   endtask
   task automatic wt(input logic v);
      int n;
      n = 0;
      while (gate !== v && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("gate", gate, v);
      if (n >= 100) summarize();
   endtask
   initial begin
      tr[0] = $urandom(53944);
      wait_cyc(5);
      rst <= 1'b0;
      wb(0, 8'h00, 0);
      chk("control", rd, 0);
      wb(0, 8'h04, 0);
      chk("fault", rd, 0);
      wb(0, 8'h20, 0);
      chk("unmapped", rd, 0);
      chk("gpio_oe", gp_oe, 1);
      chk("gpio_out", gp_out, 0);
      wait_cyc(40);
      chk("gate", gate, 0);
      wb(1, 8'h00, 32'h8);
      wt(1);
      wait_cyc(60);
      chk("gpio_oe", gp_oe, 0);
      wb(1, 8'h10, 32'h2);
      short <= 1'b1;
      wait_cyc(8);
      short <= 1'b0;
      wait_cyc(4);
      wb(0, 8'h04, 0);
      chk("fault", rd, 2);
      chk("irq", irq, 1);
      chk("alert_oe", al_oe, 0);
      wb(1, 8'h08, 32'h2);
      wait_cyc(2);
      chk("alert_oe", al_oe, 1);
      chk("alert_out", al_out, 0);
      wb(1, 8'h10, 0);
      wait_cyc(2);
      chk("irq", irq, 0);
      wb(1, 8'h04, 32'h2);
      wb(0, 8'h04, 0);
      chk("fault", rd, 0);
      req <= 1'b1;
      short <= 1'b1;
      wait_cyc(8);
      short <= 1'b0;
      wait_cyc(10);
      req <= 1'b0;
      wt(0);
      wb(0, 8'h04, 0);
      chk("fault", rd, 0);
      req <= 1'b1;
      wt(1);
      exc <= 1'b1;
      wait_cyc(1);
      exc <= 1'b0;
      wt(0);
      wb(0, 8'h04, 0);
      chk("fault", rd[0], 1);
      low_v <= 1'b1;
      wait_cyc(1);
      low_v <= 1'b0;
      wt(1);
      wb(0, 8'h04, 0);
      chk("fault", rd, 0);
      pres_n <= 1'b1;
      wt(0);
      wb(0, 8'h04, 0);
      chk("fault", rd, 4);
      for (int c = 0; c < 4; c++) begin
         wb(1, 8'h00, 32'(c * 64 + 8));
         wait_cyc(4);
         chk("gpio_oe", gp_oe, exp_pin(2'(c), 1'b0));
      end
      exc <= 1'b1;
      wait_cyc(1);
      exc <= 1'b0;
      wait_cyc(4);
      pres_n <= 1'b0;
      wt(1);
      wb(0, 8'h04, 0);
      chk("fault", rd, 4);
      for (int k = 0; k < 9; k++) begin
         for (int j = 0; j < 3; j++) begin
            tr[j] = k == 0 ? 2 : $urandom % 3;
            st_hi[j] <= tr[j] == 1;
            st_lo[j] <= tr[j] == 0;
         end
         wait_cyc(4);
         chk("bus_id", bus_id, exp_id(tr));
      end
      rst <= 1'b1;
      wait_cyc(5);
      rst <= 1'b0;
      wait_cyc(5);
      wb(0, 8'h00, 0);
      chk("control", rd[3], 0);
      wait_cyc(9);
      chk("gate", gate, 0);
      wt(1);
      wb(0, 8'h00, 0);
      chk("control", rd[3], 1);
      wb(0, 8'h04, 0);
      chk("fault", rd, 0);
      summarize();
   end
endmodule // live_insert_power_control_tb

// *** load_stage_model.sv ***
// Load side: output level sense driven by the pass switch
`timescale 1ns/1ps
module load_stage_model #(
   parameter RISE = 5
) (
   input wire i_sys_clk,
   input wire i_gate_on,
   input wire i_short,
   output logic o_level_good
);
   int cnt = 0;
   // Output ramps before reaching threshold; a short drops it at once
   always @(posedge i_sys_clk) begin
      cnt <= i_gate_on ? cnt + 1 : 0;
      o_level_good <= i_gate_on && !i_short && cnt >= RISE;
   end
endmodule // load_stage_model

// *** strap_decode.v ***
// Decodes one three-state address strap into low, high or open
`include "live_insert_consts.vh"
`timescale 1ns/1ps
module strap_decode (
   input wire i_above_hi,
   input wire i_below_lo,
   output reg [1:0] o_trit
);
   // Both comparators tripping is impossible; high wins
   always @* begin
      if (i_above_hi)
         o_trit = `TRIT_HIGH;
      else if (i_below_lo)
         o_trit = `TRIT_LOW;
      else
         o_trit = `TRIT_OPEN;
   end
endmodule // strap_decode
